// *** hw/i2c_slave_stretch.v ***
// i2c slave with clock stretching, address/data hold, 10-bit addressing and rx fifo
`timescale 1ns/1ps
`include "i2c_slave_consts.vh"

module rx_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 8,
    parameter AW    = 3
) (
    input  wire             clk_sys,
    input  wire             nrst,
    input  wire             in_valid,
    output wire             in_ready,
    input  wire [WIDTH-1:0] in_data,
    output wire             out_valid,
    input  wire             out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wp;
    reg [AW-1:0]    rp;
    reg [AW:0]      cnt;
    wire            push;
    wire            pop;

    assign in_ready  = (cnt != DEPTH[AW:0]);
    assign out_valid = (cnt != {(AW+1){1'b0}});
    assign out_data  = mem[rp];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    // pointers and fill count
    always @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            wp  <= {AW{1'b0}};
            rp  <= {AW{1'b0}};
            cnt <= {(AW+1){1'b0}};
        end
        else
        begin
            if (push)
            begin
                mem[wp] <= in_data;
                wp      <= wp + 1'b1;
            end
            if (pop)
                rp <= rp + 1'b1;
            if (push & !pop)
                cnt <= cnt + 1'b1;
            else if (pop & !push)
                cnt <= cnt - 1'b1;
        end
    end
endmodule

module i2c_slave_stretch (
    input  wire       clk_sys,
    input  wire       nrst,
    input  wire       scl_in,
    output reg        scl_out,
    output reg        scl_oe,
    input  wire       sda_in,
    output reg        sda_out,
    output reg        sda_oe,
    input  wire       address_hold_enable,
    input  wire       data_hold_enable,
    input  wire       clock_stretch_enable,
    input  wire       ten_bit_mode,
    input  wire       start_int_enable,
    input  wire [7:0] addr_wdata,
    input  wire       addr_write,
    output reg  [7:0] slave_address_register,
    input  wire       ack_value_bit,
    input  wire       release_set,
    input  wire       flag_clear,
    input  wire [7:0] tx_data,
    input  wire       tx_load,
    input  wire       buf_read,
    output reg  [7:0] serial_buffer,
    output reg        buffer_full_flag,
    output reg        serial_interrupt_flag,
    output reg        clock_release_bit,
    output reg        ack_time_flag,
    output reg        ack_status_bit,
    output reg        update_address_flag,
    output reg        start_seen,
    output reg        stop_seen,
    output reg        read_write_bit,
    output reg        data_address_bit,
    output reg        rx_valid,
    input  wire       rx_ready,
    output reg  [7:0] rx_data,
    output reg        rx_stall
);
    // ---------------------------------------------------------------
    // pin synchronisers and edge detection
    // ---------------------------------------------------------------
    reg [1:0] scl_sync;
    reg [1:0] sda_sync;
    reg       scl_d;
    reg       sda_d;
    wire      scl_s  = scl_sync[1];
    wire      sda_s  = sda_sync[1];
    wire      scl_rise = scl_s & !scl_d;
    wire      scl_fall = !scl_s & scl_d;
    wire      start_c  = scl_s & scl_d & sda_d & !sda_s;
    wire      stop_c   = scl_s & scl_d & !sda_d & sda_s;

    // two stages then a delayed copy for edges
    always @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            scl_sync <= 2'h3;
            sda_sync <= 2'h3;
            scl_d    <= 1'b1;
            sda_d    <= 1'b1;
        end
        else
        begin
            scl_sync <= {scl_sync[0], scl_in};
            sda_sync <= {sda_sync[0], sda_in};
            scl_d    <= scl_s;
            sda_d    <= sda_s;
        end
    end

    // ---------------------------------------------------------------
    // receive fifo in the data path
    // ---------------------------------------------------------------
    reg        f_push;
    reg  [7:0] f_data;
    wire       f_ready;
    wire       f_valid;
    wire [7:0] f_out;

    rx_fifo #(.WIDTH(8), .DEPTH(`FIFO_DEPTH), .AW(3)) u_fifo (
        .clk_sys   (clk_sys),
        .nrst      (nrst),
        .in_valid  (f_push),
        .in_ready  (f_ready),
        .in_data   (f_data),
        .out_valid (f_valid),
        .out_ready (rx_ready & rx_valid),
        .out_data  (f_out)
    );

    // ---------------------------------------------------------------
    // address decode helper
    // ---------------------------------------------------------------
    function addr_hit;
        input [7:0] rx;
        input [7:0] adr;
        input       ten;
        input       first;
        begin
            if (ten & first)
                addr_hit = (rx[7:3] == `TEN_HI_PFX) && (rx[2:1] == adr[2:1]);
            else if (ten)
                addr_hit = (rx == adr);
            else
                addr_hit = (rx[7:1] == adr[7:1]);
        end
    endfunction

    // ---------------------------------------------------------------
    // byte engine
    // ---------------------------------------------------------------
    reg [2:0] state;
    reg [3:0] bitcnt;
    reg [7:0] shreg;
    reg       matched;
    reg       first_byte;
    reg       hold_req;
    reg       ack_drive;
    reg       ten_low;

    always @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            state <= `ST_IDLE;
            bitcnt <= 4'h0;
            shreg <= 8'h00;
            matched <= 1'b0;
            first_byte <= 1'b0;
            ten_low <= 1'b0;
            hold_req <= 1'b0;
            ack_drive <= 1'b0;
            scl_out <= 1'b0;
            scl_oe <= 1'b0;
            sda_out <= 1'b0;
            sda_oe <= 1'b0;
            slave_address_register <= 8'h00;
            serial_buffer <= 8'h00;
            buffer_full_flag <= 1'b0;
            serial_interrupt_flag <= 1'b0;
            clock_release_bit <= 1'b1;
            ack_time_flag <= 1'b0;
            ack_status_bit <= 1'b0;
            update_address_flag <= 1'b0;
            start_seen <= 1'b0;
            stop_seen <= 1'b0;
            read_write_bit <= 1'b0;
            data_address_bit <= 1'b0;
            f_push <= 1'b0;
            f_data <= 8'h00;
            rx_valid <= 1'b0;
            rx_data <= 8'h00;
            rx_stall <= 1'b0;
        end
        else
        begin
            f_push   <= 1'b0;
            rx_valid <= f_valid;
            rx_data  <= f_out;
            rx_stall <= !f_ready;
            // software side effects; hardware sets below win
            if (flag_clear)
                serial_interrupt_flag <= 1'b0;
            if (buf_read)
                buffer_full_flag <= 1'b0;
            if (release_set)
                clock_release_bit <= 1'b1;
            if (tx_load)
            begin
                serial_buffer <= tx_data;
                shreg <= tx_data;
                buffer_full_flag <= 1'b1;
                // first bit of a fresh byte goes out while scl is held
                if (state == `ST_TX && bitcnt == 4'h0)
                    sda_oe <= !tx_data[7];
            end
            if (addr_write)
            begin
                slave_address_register <= addr_wdata;
                update_address_flag <= 1'b0;
            end
            if (stop_c)
            begin
                stop_seen <= 1'b1;
                start_seen <= 1'b0;
                state <= `ST_IDLE;
                sda_oe <= 1'b0;
            end
            if (start_c)
            begin
                start_seen <= 1'b1;
                stop_seen <= 1'b0;
                if (start_int_enable)
                    serial_interrupt_flag <= 1'b1;
                state <= `ST_ADDR;
                bitcnt <= 4'h0;
                first_byte <= 1'b1;
                ten_low <= 1'b0;
                matched <= 1'b0;
                sda_oe <= 1'b0;
            end
            else if (scl_rise)
            begin
                case (state)
                    `ST_ADDR, `ST_RX:
                    begin
                        shreg <= {shreg[6:0], sda_s};
                        bitcnt <= bitcnt + 4'h1;
                    end
                    `ST_TXACK:
                    begin
                        // master ack sampled on 9th rise
                        ack_status_bit <= sda_s;
                    end
                    default:
                        bitcnt <= bitcnt;
                endcase
            end
            else if (scl_fall)
            begin
                case (state)
                    `ST_ADDR, `ST_RX:
                    begin
                        if (bitcnt == 4'h8)
                        begin
                            ack_drive <= 1'b1;
                            hold_req <= 1'b0;
                            if (state == `ST_ADDR)
                            begin
                                if (addr_hit(shreg, slave_address_register, ten_bit_mode,
                                             first_byte))
                                begin
                                    matched <= 1'b1;
                                    read_write_bit <= shreg[0] & first_byte;
                                    data_address_bit <= 1'b0;
                                    serial_buffer <= shreg;
                                    buffer_full_flag <= 1'b1;
                                    if (ten_bit_mode & first_byte & !shreg[0])
                                        update_address_flag <= 1'b1;
                                    if (ten_bit_mode & !first_byte)
                                        update_address_flag <= 1'b1;
                                    if (address_hold_enable)
                                    begin
                                        clock_release_bit <= 1'b0;
                                        serial_interrupt_flag <= 1'b1;
                                        hold_req <= 1'b1;
                                    end
                                end
                                else if (ten_bit_mode & ten_low)
                                begin
                                    serial_interrupt_flag <= 1'b1;
                                    update_address_flag <= 1'b1;
                                    matched <= 1'b0;
                                    ack_drive <= 1'b0;
                                end
                                else
                                begin
                                    matched <= 1'b0;
                                    ack_drive <= 1'b0;
                                end
                            end
                            else
                            begin
                                data_address_bit <= 1'b1;
                                serial_buffer <= shreg;
                                buffer_full_flag <= 1'b1;
                                f_data <= shreg;
                                f_push <= 1'b1;
                                if (data_hold_enable)
                                begin
                                    clock_release_bit <= 1'b0;
                                    serial_interrupt_flag <= 1'b1;
                                    hold_req <= 1'b1;
                                end
                            end
                            ack_time_flag <= 1'b1;
                            state <= `ST_ACK;
                        end
                    end
                    `ST_ACK:
                    begin
                        // end of ack slot: 9th falling edge
                        ack_time_flag <= 1'b0;
                        sda_oe <= 1'b0;
                        bitcnt <= 4'h0;
                        if (ack_drive & !ack_value_bit)
                        begin
                            serial_interrupt_flag <= 1'b1;
                            if (read_write_bit & !data_address_bit)
                            begin
                                clock_release_bit <= 1'b0;
                                state <= `ST_TX;
                                sda_oe <= !shreg[7];
                            end
                            else
                            begin
                                if (clock_stretch_enable)
                                    clock_release_bit <= 1'b0;
                                if (first_byte & ten_bit_mode & !read_write_bit)
                                    ten_low <= 1'b1;
                                else
                                    ten_low <= 1'b0;
                                // only the high byte is followed by a second address byte
                                state <= (first_byte & ten_bit_mode) ? `ST_ADDR : `ST_RX;
                                first_byte <= 1'b0;
                            end
                        end
                        else
                            state <= `ST_IDLE;
                    end
                    `ST_TX:
                    begin
                        bitcnt <= bitcnt + 4'h1;
                        shreg <= {shreg[6:0], 1'b1};
                        if (bitcnt == 4'h7)
                        begin
                            sda_oe <= 1'b0;
                            buffer_full_flag <= 1'b0;
                            state <= `ST_TXACK;
                        end
                        else
                            sda_oe <= !shreg[6];
                    end
                    `ST_TXACK:
                    begin
                        serial_interrupt_flag <= 1'b1;
                        bitcnt <= 4'h0;
                        if (ack_status_bit)
                            state <= `ST_IDLE;
                        else
                        begin
                            clock_release_bit <= 1'b0;
                            state <= `ST_TX;
                            sda_oe <= !shreg[7];
                        end
                    end
                    default:
                        bitcnt <= 4'h0;
                endcase
            end
            // drive ack in the slot; software ack value only when a hold was requested
            if (state == `ST_ACK && !scl_s && !scl_d)
                sda_oe <= ack_drive & (hold_req ? !ack_value_bit : 1'b1);
            // hold scl only once sampled low; free when released
            // update flag holds only once the ack slot is over
            if (!scl_s && (!clock_release_bit || (update_address_flag && state != `ST_ACK)))
                scl_oe <= 1'b1;
            else if (clock_release_bit && !update_address_flag)
                scl_oe <= 1'b0;
        end
    end
endmodule

// *** hw/i2c_slave_consts.vh ***
// constants for the i2c slave with clock stretching and address hold
`ifndef I2C_SLAVE_CONSTS_VH
`define I2C_SLAVE_CONSTS_VH
`define ST_IDLE   3'h0
`define ST_ADDR   3'h1
`define ST_ACK    3'h2
`define ST_RX     3'h3
`define ST_TX     3'h4
`define ST_TXACK  3'h5
`define TEN_HI_PFX 5'h1e
`define FIFO_DEPTH 8
`endif

// *** dv/i2c_slave_stretch_assertions.sv ***
// concurrent checks on the ports of the i2c slave
`timescale 1ns/1ps
module i2c_slave_stretch_assertions (
    input wire logic       clk_sys,
    input wire logic       nrst,
    input wire logic       scl_in,
    input wire logic       scl_oe,
    input wire logic       start_int_enable,
    input wire logic       addr_write,
    input wire logic       release_set,
    input wire logic       tx_load,
    input wire logic [7:0] tx_data,
    input wire logic       buf_read,
    input wire logic [7:0] serial_buffer,
    input wire logic       buffer_full_flag,
    input wire logic       serial_interrupt_flag,
    input wire logic       clock_release_bit,
    input wire logic       update_address_flag,
    input wire logic       start_seen,
    input wire logic       rx_stall
);
    // ------------------------------
    // scl holding and status flags
    // ------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    a_hold_after_low: assert property ($rose(scl_oe) |-> !$past(scl_in, 3))
        else $error("scl held while high");
    a_release_frees: assert property (release_set && !update_address_flag |-> ##[1:4] !scl_oe)
        else $error("scl kept after release");
    a_hold_until_ckp: assert property ($fell(scl_oe) |-> clock_release_bit)
        else $error("scl freed with release bit low");
    a_read_clears_full: assert property (buf_read && !tx_load |=> !buffer_full_flag)
        else $error("buffer full kept after read");
    a_load_sets_full: assert property (tx_load |=> buffer_full_flag && serial_buffer == $past(tx_data))
        else $error("load did not fill buffer");
    a_update_keeps_ckp: assert property ($rose(update_address_flag) |-> clock_release_bit == $past(clock_release_bit))
        else $error("release bit moved with update flag");
    a_addr_write_frees: assert property (addr_write && clock_release_bit |-> ##[1:4] !scl_oe)
        else $error("scl kept after address write");
    a_start_flag: assert property ($rose(start_seen) && start_int_enable |-> ##[0:1] serial_interrupt_flag)
        else $error("no flag on start");
    c_hold: cover property ($rose(scl_oe));
    c_update: cover property ($rose(update_address_flag));
    c_full: cover property ($rose(rx_stall));
endmodule

bind i2c_slave_stretch i2c_slave_stretch_assertions u_chk (
    .clk_sys, .nrst, .scl_in, .scl_oe, .start_int_enable, .addr_write, .release_set, .tx_load,
    .tx_data, .buf_read, .serial_buffer, .buffer_full_flag, .serial_interrupt_flag,
    .clock_release_bit, .update_address_flag, .start_seen, .rx_stall
);

// *** dv/i2c_master_model.sv ***
// behavioural i2c bus master, open drain, 800 ns bit period
`timescale 1ns/1ps
module i2c_master_model (
    output logic     scl_pull,
    output logic     sda_pull,
    input wire logic scl_line,
    input wire logic sda_line
);
    int stuck = 0;
    // lines released at start
    initial
    begin
        scl_pull = 1'b0;
        sda_pull = 1'b0;
    end
    // ------------------------
    // bit and byte signalling
    // ------------------------
    // release scl, then wait while a slave stretches it
    task automatic scl_up();
        int n;
        n = 0;
        scl_pull = 1'b0;
        while (scl_line !== 1'b1 && n < 5000)
        begin
            #100;
            n++;
        end
        if (n == 5000) stuck++;
    endtask
    // sda moves in the low phase and is sampled mid high
    task automatic bit_io(input logic b, output logic r);
        #200 sda_pull = ~b;
        #200 scl_up();
        #200 r = sda_line;
        #200 scl_pull = 1'b1;
    endtask
    // offset keeps bus edges away from the system clock edge
    task automatic start();
        #20 sda_pull = 1'b1;
        #400 scl_pull = 1'b1;
    endtask
    task automatic stop();
        #200 sda_pull = 1'b1;
        #200 scl_up();
        #400 sda_pull = 1'b0;
        #400;
    endtask
    task automatic write_byte(input logic [7:0] v, output logic ack);
        for (int i = 7; i >= 0; i--) bit_io(v[i], ack);
        bit_io(1'b1, ack);
    endtask
    // caller passes nack on the last byte
    task automatic read_byte(input logic nack, output logic [7:0] v);
        logic r;
        for (int i = 7; i >= 0; i--)
        begin
            bit_io(1'b1, r);
            v[i] = r;
        end
        bit_io(nack, r);
    endtask
endmodule

// *** dv/tb_top.sv ***
// self-checking bench for the i2c slave with clock stretching
`timescale 1ns/1ps
module tb_top;
    localparam logic [7:0] ADR7   = 8'h84;
    localparam logic [7:0] ADR_HI = 8'hf2;
    localparam logic [7:0] ADR_LO = 8'ha5;
    logic        clk_sys, nrst, address_hold_enable, data_hold_enable, clock_stretch_enable;
    logic        ten_bit_mode, start_int_enable, addr_write, ack_value_bit, release_set;
    logic        flag_clear, tx_load, buf_read, rx_ready, sw_on, ld, a;
    logic [7:0]  addr_wdata, tx_data, d;
    logic [7:0]  tx_q [2];
    logic [11:0] rows [4] = '{12'h884, 12'h186, 12'h784, 12'h484};
    int          bad_count, n_tests, n_hold, n_ua, tx_i, n;
    wire         scl_out, scl_oe, sda_out, sda_oe, buffer_full_flag, serial_interrupt_flag;
    wire         clock_release_bit, ack_time_flag, ack_status_bit, update_address_flag;
    wire         start_seen, stop_seen, read_write_bit, data_address_bit, rx_valid, rx_stall;
    wire  [7:0]  slave_address_register, serial_buffer, rx_data;
    wire         m_scl, m_sda;
    wire         scl_line = ~(m_scl | (scl_oe & ~scl_out));
    wire         sda_line = ~(m_sda | (sda_oe & ~sda_out));

    i2c_slave_stretch uut (
        .clk_sys, .nrst, .scl_in(scl_line), .scl_out, .scl_oe, .sda_in(sda_line), .sda_out,
        .sda_oe, .address_hold_enable, .data_hold_enable, .clock_stretch_enable, .ten_bit_mode,
        .start_int_enable, .addr_wdata, .addr_write, .slave_address_register, .ack_value_bit,
        .release_set, .flag_clear, .tx_data, .tx_load, .buf_read, .serial_buffer,
        .buffer_full_flag, .serial_interrupt_flag, .clock_release_bit, .ack_time_flag,
        .ack_status_bit, .update_address_flag, .start_seen, .stop_seen, .read_write_bit,
        .data_address_bit, .rx_valid, .rx_ready, .rx_data, .rx_stall
    );
    i2c_master_model m (.scl_pull(m_scl), .sda_pull(m_sda), .scl_line, .sda_line);

    // --------------------
    // helpers and checks
    // --------------------
    always #50 clk_sys = ~clk_sys;
    task automatic cyc(input int k);
        repeat (k) @(posedge clk_sys);
    endtask
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        check({7'h00, got}, {7'h00, exp});
    endtask
    task automatic set_addr(input logic [7:0] v);
        addr_wdata <= v;
        addr_write <= 1'b1;
        cyc(1);
        addr_write <= 1'b0;
    endtask
    task automatic do_reset();
        nrst <= 1'b0;
        cyc(6);
        nrst <= 1'b1;
        cyc(3);
        check({3'h0, clock_release_bit, serial_interrupt_flag, buffer_full_flag, scl_oe, sda_oe},
              8'h10);
        check(slave_address_register, 8'h00);
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // interrupt service: clear, read or load, readdress, release
    initial forever
    begin
        @(posedge clk_sys);
        if (sw_on && serial_interrupt_flag === 1'b1)
        begin
            cyc(20);
            if (clock_release_bit === 1'b0) n_hold++;
            if (update_address_flag === 1'b1) n_ua++;
            // load only once the ack is over
            ld = read_write_bit === 1'b1 && ack_time_flag === 1'b0 && tx_i < 2;
            flag_clear <= 1'b1;
            buf_read <= ~ld;
            tx_load <= ld;
            tx_data <= tx_q[tx_i % 2];
            if (ld) tx_i++;
            // swap high and low address bytes
            if (update_address_flag === 1'b1)
            begin
                addr_wdata <= (slave_address_register === ADR_HI) ? ADR_LO : ADR_HI;
                addr_write <= 1'b1;
            end
            cyc(1);
            {flag_clear, buf_read, tx_load, addr_write} <= 4'h0;
            release_set <= 1'b1;
            cyc(1);
            release_set <= 1'b0;
        end
    end

    // watchdog against a hung bus
    initial
    begin
        #3000000;
        bad_count++;
        stop_test();
    end

    // main sequence
    initial
    begin
        {clk_sys, nrst, address_hold_enable, data_hold_enable, clock_stretch_enable,
         ten_bit_mode, start_int_enable, addr_write, ack_value_bit, release_set, flag_clear,
         tx_load, buf_read, rx_ready, sw_on} = 15'h0000;
        addr_wdata = 8'h00;
        tx_data = 8'h00;
        do_reset();
        set_addr(ADR7);
        // table: start flag enable, address hold, ack value, expected ack, address
        foreach (rows[i])
        begin
            {start_int_enable, address_hold_enable, ack_value_bit} <= rows[i][11:9];
            sw_on <= 1'b0;
            cyc(1);
            m.start();
            cyc(10);
            chk1(start_seen, 1'b1);
            chk1(serial_interrupt_flag, rows[i][11]);
            sw_on <= 1'b1;
            m.write_byte(rows[i][7:0], a);
            chk1(a, rows[i][8]);
            m.stop();
            cyc(40);
        end
        // address hold on a read, two bytes sent back
        {start_int_enable, ack_value_bit} <= 2'b00;
        tx_q = '{8'ha7, 8'h5b};
        tx_i = 0;
        n_hold = 0;
        cyc(1);
        m.start();
        m.write_byte(ADR7 | 8'h01, a);
        chk1(a, 1'b0);
        m.read_byte(1'b0, d);
        check(d, 8'ha7);
        chk1(ack_status_bit, 1'b0);
        m.read_byte(1'b1, d);
        check(d, 8'h5b);
        cyc(10);
        chk1(ack_status_bit, 1'b1);
        chk1(scl_oe, 1'b0);
        check(serial_buffer, 8'h5b);
        chk1(read_write_bit, 1'b1);
        m.stop();
        cyc(40);
        check(8'(n_hold), 8'h03);
        // data hold and stretch, fifo filled past its depth then drained
        {address_hold_enable, data_hold_enable, clock_stretch_enable} <= 3'b011;
        n_hold = 0;
        cyc(1);
        m.start();
        m.write_byte(ADR7, a);
        for (int i = 0; i < 9; i++)
        begin
            m.write_byte(8'h10 + 8'(i), a);
            if (i < 8) chk1(a, 1'b0);
        end
        m.stop();
        cyc(40);
        chk1(rx_stall, 1'b1);
        chk1(n_hold >= 18, 1'b1);
        chk1(data_address_bit, 1'b1);
        chk1(stop_seen, 1'b1);
        for (int i = 0; i < 8; i++)
        begin
            n = 0;
            do
            begin
                @(negedge clk_sys);
                n++;
            end
            while (rx_valid !== 1'b1 && n < 50);
            check(rx_data, 8'h10 + 8'(i));
            @(posedge clk_sys) rx_ready <= 1'b1;
            cyc(1);
            rx_ready <= 1'b0;
            // registered fifo output needs a further cycle to show the next word
            cyc(2);
        end
        cyc(3);
        check({6'h00, rx_valid, rx_stall}, 8'h00);
        // ten bit addressing, then a low byte that misses
        {data_hold_enable, clock_stretch_enable, ten_bit_mode} <= 3'b001;
        n_ua = 0;
        set_addr(ADR_HI);
        m.start();
        m.write_byte(ADR_HI, a);
        chk1(a, 1'b0);
        m.write_byte(ADR_LO, a);
        chk1(a, 1'b0);
        m.write_byte(8'h77, a);
        chk1(a, 1'b0);
        m.stop();
        cyc(40);
        m.start();
        m.write_byte(ADR_HI, a);
        m.write_byte(ADR_LO + 8'h01, a);
        chk1(a, 1'b1);
        m.stop();
        cyc(40);
        check(8'(n_ua), 8'h04);
        check(slave_address_register, ADR_HI);
        // second reset after the last transfer
        do_reset();
        check(8'(m.stuck), 8'h00);
        stop_test();
    end
endmodule
